// ==== logic/tsm_regs.svh ====
// Constants for the tributary slot multiplexer
// Summary of operation
// RULE1 - In the 40-slot container, multiframe index n selects slot n+1 overhead.
// RULE2 - Asynchronous units exist only for order pairs 0-1, 1-2, 1-3, 2-3.
// RULE3 - Generic units accept ts ranges 1..8, 1..32, 1..80, 1..20, 1..40.
// RULE4 - Asynchronous unit overhead is four bytes per slot, one may carry payload.
// RULE5 - Asynchronous per-slot overhead follows used slots, spacing may be uneven.
// RULE6 - 2.5G asynchronous payload sizes 952x16, 238x64, 952x64.
// RULE7 - 1.25G asynchronous payload sizes 1904x8, 952x32, 238x128, 952x128.
// RULE8 - Generic unit payload is j*ts columns by r rows, six overhead bytes.
// RULE9 - Generic (j,r) per order: (476,32) (119,128) (95,160) (952,16) (476,32).
// RULE10 - Generic unit overhead rides in its highest-numbered allocated slot.
// RULE11 - Order pair 0-1 uses one of the two order-1 slots.
// RULE12 - Pair 1-2 uses one of four 2.5G slots or two ascending of eight.
// RULE13 - Pair 1-3 uses one of sixteen 2.5G slots or two ascending of 32.
// RULE14 - Pair 2-3 uses four ascending of 16 or eight ascending of 32.
// RULE15 - Any ascending, non-consecutive slot choice is accepted.
// RULE16 - Generic unit uses ts ascending 1.25G slots of 8, 32, 80, 20 or 40.
// RULE17 - Container overhead flags the multiframe identifier for order 4.
// RULE18 - Report 1.25G allocations equal to the 2.5G form.
// RULE19 - Asynchronous overhead is three control bytes plus one opportunity byte.
// RULE20 - Generic overhead sits in columns 15 and 16, rows 1 to 3.
// RULE21 - Reject and flag non-ascending, out-of-range or miscounted allocations.
// RULE22 - Multiframe counter visits every slot overhead once, ascending.
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH
`define TSM_TS_O1 7'h02
`define TSM_TS_O2 7'h08
`define TSM_TS_O2_25 7'h04
`define TSM_TS_O3 7'h20
`define TSM_TS_O3_25 7'h10
`define TSM_TS_O4 7'h50
`define TSM_TS_O25 7'h14
`define TSM_TS_O50 7'h28
`define TSM_REQ_ONE 7'h01
`define TSM_REQ_TWO 7'h02
`define TSM_REQ_23_25 7'h04
`define TSM_REQ_23 7'h08
`define TSM_C01 15'h0770
`define TSM_C_WIDE 15'h03B8
`define TSM_C_NARROW 15'h00EE
`define TSM_R01 8'h08
`define TSM_R12_25 8'h10
`define TSM_R13_25 8'h40
`define TSM_R12 8'h20
`define TSM_R13 8'h80
`define TSM_J2 15'h01DC
`define TSM_J3 15'h0077
`define TSM_J4 15'h005F
`define TSM_J25 15'h03B8
`define TSM_R4 8'hA0
`define TSM_OH_AMP 3'h4
`define TSM_OH_GMP 3'h6
`define TSM_JC_BYTES 3'h3
`define TSM_NJO_BYTES 3'h1
`define TSM_COL_GMP 5'h0F
`define TSM_COL_AMP 5'h10
`define TSM_GMP_ROWS 3'h3
`endif

// ==== logic/tsm_pkg.sv ====
// Types and shared helpers for the tributary slot multiplexer
`include "tsm_regs.svh"
package tsm_pkg;
  typedef enum logic [3:0] {
    TSM_AMP01, TSM_AMP12, TSM_AMP13, TSM_AMP23,
    TSM_GMP2, TSM_GMP3, TSM_GMP4, TSM_GMP25, TSM_GMP50
  } tsm_unit_t;

  function automatic logic tsm_is_gmp(input tsm_unit_t u);
    tsm_is_gmp = (u >= TSM_GMP2);
  endfunction : tsm_is_gmp

  // Slots in the container at the chosen granularity
  function automatic logic [6:0] tsm_slots(input tsm_unit_t u, input logic g25);
    case (u)
      TSM_AMP01: tsm_slots = `TSM_TS_O1; // RULE11
      TSM_AMP12, TSM_GMP2: tsm_slots = g25 ? `TSM_TS_O2_25 : `TSM_TS_O2; // RULE12
      TSM_AMP13, TSM_AMP23, TSM_GMP3:
        tsm_slots = g25 ? `TSM_TS_O3_25 : `TSM_TS_O3; // RULE13 RULE14
      TSM_GMP4: tsm_slots = `TSM_TS_O4; // RULE16
      TSM_GMP25: tsm_slots = `TSM_TS_O25;
      TSM_GMP50: tsm_slots = `TSM_TS_O50;
      default: tsm_slots = 7'h00;
    endcase
  endfunction : tsm_slots

  // Slots a unit must occupy
  function automatic logic [6:0] tsm_req(input tsm_unit_t u, input logic g25,
                                         input logic [6:0] ts);
    case (u)
      TSM_AMP01: tsm_req = `TSM_REQ_ONE;
      TSM_AMP12, TSM_AMP13: tsm_req = g25 ? `TSM_REQ_ONE : `TSM_REQ_TWO;
      TSM_AMP23: tsm_req = g25 ? `TSM_REQ_23_25 : `TSM_REQ_23; // RULE14
      default: tsm_req = ts;
    endcase
  endfunction : tsm_req

  // Legal unit, granularity and ts combination
  function automatic logic tsm_cfg_ok(input tsm_unit_t u, input logic g25,
                                      input logic [6:0] ts);
    case (u)
      TSM_AMP12, TSM_AMP13, TSM_AMP23: tsm_cfg_ok = 1'b1; // RULE2
      TSM_AMP01: tsm_cfg_ok = !g25;
      TSM_GMP2, TSM_GMP3, TSM_GMP4, TSM_GMP25, TSM_GMP50:
        tsm_cfg_ok = !g25 && ts != 7'h00 && ts <= tsm_slots(u, 1'b0); // RULE3
      default: tsm_cfg_ok = 1'b0;
    endcase
  endfunction : tsm_cfg_ok

  // Payload columns
  function automatic logic [14:0] tsm_cols(input tsm_unit_t u, input logic [6:0] ts);
    case (u)
      TSM_AMP01: tsm_cols = `TSM_C01; // RULE7
      TSM_AMP12, TSM_AMP23: tsm_cols = `TSM_C_WIDE; // RULE6
      TSM_AMP13: tsm_cols = `TSM_C_NARROW;
      TSM_GMP2, TSM_GMP50: tsm_cols = 15'(`TSM_J2 * {8'h00, ts}); // RULE8 RULE9
      TSM_GMP3: tsm_cols = 15'(`TSM_J3 * {8'h00, ts});
      TSM_GMP4: tsm_cols = 15'(`TSM_J4 * {8'h00, ts});
      TSM_GMP25: tsm_cols = 15'(`TSM_J25 * {8'h00, ts});
      default: tsm_cols = 15'h0000;
    endcase
  endfunction : tsm_cols

  // Payload rows
  function automatic logic [7:0] tsm_rows(input tsm_unit_t u, input logic g25);
    case (u)
      TSM_AMP01: tsm_rows = `TSM_R01; // RULE7
      TSM_AMP12, TSM_GMP2, TSM_GMP50: tsm_rows = (g25 && u == TSM_AMP12) ?
        `TSM_R12_25 : `TSM_R12; // RULE6 RULE9
      TSM_AMP13, TSM_AMP23, TSM_GMP3: tsm_rows = (g25 && u != TSM_GMP3) ?
        `TSM_R13_25 : `TSM_R13;
      TSM_GMP4: tsm_rows = `TSM_R4;
      TSM_GMP25: tsm_rows = `TSM_R12_25;
      default: tsm_rows = 8'h00;
    endcase
  endfunction : tsm_rows
endpackage : tsm_pkg

// ==== logic/tsm_alloc_check.sv ====
// Streamed slot allocation checker
`timescale 1ns/1ps
module tsm_alloc_check #(
  parameter int MAX_TS = 80
) (
  input wire logic clk_in, // System clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire tsm_pkg::tsm_unit_t unit_in, // Unit type
  input wire logic g25_in, // 2.5G slots when high
  input wire logic [6:0] ts_in, // Generic slot count
  input wire logic start_in, // Begin new allocation
  input wire logic valid_in, // Slot number valid
  input wire logic [6:0] slot_in, // Slot number, 1-based
  input wire logic last_in, // Final slot of allocation
  output logic [MAX_TS-1:0] map_out, // Allocated slot bitmap
  output logic [6:0] last_slot_out, // Highest slot
  output logic acc_out, // Accept pulse
  output logic err_out // Reject pulse
);
  logic busy_q;
  logic bad_q;
  logic [6:0] cnt_q;
  logic bad_now;

  // Ascending, range and count checks on the current slot
  assign bad_now = bad_q || slot_in <= last_slot_out || // RULE15 RULE21
                   slot_in > tsm_pkg::tsm_slots(unit_in, g25_in) ||
                   cnt_q >= tsm_pkg::tsm_req(unit_in, g25_in, ts_in) ||
                   !tsm_pkg::tsm_cfg_ok(unit_in, g25_in, ts_in);

  // Collect slots and decide at the last one
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      map_out <= '0;
      last_slot_out <= 7'h00;
      cnt_q <= 7'h00;
      bad_q <= 1'b0;
      busy_q <= 1'b0;
      acc_out <= 1'b0;
      err_out <= 1'b0;
    end
    else
    begin
      acc_out <= 1'b0;
      err_out <= 1'b0;
      if (start_in)
      begin
        map_out <= '0;
        last_slot_out <= 7'h00;
        cnt_q <= 7'h00;
        bad_q <= 1'b0;
        busy_q <= 1'b1;
      end
      else if (busy_q && valid_in)
      begin
        if (slot_in != 7'h00 && slot_in <= 7'(MAX_TS))
          map_out[7'(slot_in - 7'h01)] <= 1'b1;
        last_slot_out <= slot_in;
        cnt_q <= 7'(cnt_q + 7'h01);
        bad_q <= bad_now;
        if (last_in)
        begin
          busy_q <= 1'b0;
          if (bad_now || 7'(cnt_q + 7'h01) != tsm_pkg::tsm_req(unit_in, g25_in, ts_in))
            err_out <= 1'b1; // RULE21
          else
            acc_out <= 1'b1;
        end
      end
    end
  end
endmodule : tsm_alloc_check

// ==== logic/tsm_slot_mux.sv ====
// Tributary slot multiplexer: allocation, multiframe and overhead placement
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_slot_mux #(
  parameter int MAX_TS = 80
) (
  input wire logic clk_in, // System clock, 25 MHz
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic frame_start_in, // One pulse per frame
  input wire tsm_pkg::tsm_unit_t unit_in, // Unit type to provision
  input wire logic g25_in, // 2.5G slots when high
  input wire logic [6:0] ts_in, // Generic slot count
  input wire logic prov_start_in, // Start allocation
  input wire logic prov_valid_in, // Slot number valid
  input wire logic [6:0] prov_slot_in, // Slot number, 1-based
  input wire logic prov_last_in, // Final slot
  output logic alloc_ok_out, // Last completed allocation accepted
  output logic alloc_err_out, // Allocation rejected
  output logic [6:0] mf_id_out, // Multiframe index
  output logic [6:0] tsoh_owner_out, // Slot owning this overhead
  output logic tsoh_mine_out, // Slot belongs to the unit
  output logic tsoh_unit_oh_out, // Unit overhead here
  output logic tsoh_rsv_out, // Overhead bytes reserved
  output logic [2:0] oh_bytes_out, // Unit overhead bytes
  output logic oh_njo_out, // One byte may carry payload
  output logic [4:0] oh_col_out, // First overhead column
  output logic [2:0] oh_rows_out, // Overhead rows
  output logic [14:0] pay_cols_out, // Payload columns
  output logic [7:0] pay_rows_out, // Payload rows
  output logic omfi_en_out, // Identifier byte present
  output logic equiv_out // 1.25G form equals 2.5G form
);
  tsm_pkg::tsm_unit_t live_unit_q;
  logic live_g25_q;
  logic [6:0] live_ts_q;
  logic [MAX_TS-1:0] live_map_q;
  logic [6:0] live_last_q;
  logic live_q;
  logic [6:0] mf_q;
  logic [6:0] per;
  logic wrap;
  logic gmp_live;
  logic mine;
  logic unit_oh;
  logic [MAX_TS-1:0] chk_map;
  logic [6:0] chk_last;
  logic chk_acc;
  logic chk_err;

  // Allocation checker
  tsm_alloc_check #(
    .MAX_TS(MAX_TS)
  ) tsm_alloc_check_inst (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .unit_in(unit_in),
    .g25_in(g25_in),
    .ts_in(ts_in),
    .start_in(prov_start_in),
    .valid_in(prov_valid_in),
    .slot_in(prov_slot_in),
    .last_in(prov_last_in),
    .map_out(chk_map),
    .last_slot_out(chk_last),
    .acc_out(chk_acc),
    .err_out(chk_err)
  );

  // Configuration in force, taken only on acceptance
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      live_unit_q <= tsm_pkg::TSM_AMP01;
      live_g25_q <= 1'b0;
      live_ts_q <= 7'h00;
      live_map_q <= '0;
      live_last_q <= 7'h00;
      live_q <= 1'b0;
    end
    else if (chk_acc)
    begin
      live_unit_q <= unit_in;
      live_g25_q <= g25_in;
      live_ts_q <= ts_in;
      live_map_q <= chk_map;
      live_last_q <= chk_last;
      live_q <= 1'b1;
    end
  end

  // Acceptance and rejection flags; a reject wins over a new start
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      alloc_ok_out <= 1'b0;
      alloc_err_out <= 1'b0;
    end
    else
    begin
      if (chk_err)
      begin
        alloc_err_out <= 1'b1; // RULE21
        alloc_ok_out <= 1'b0;
      end
      else if (chk_acc)
      begin
        alloc_err_out <= 1'b0;
        alloc_ok_out <= 1'b1;
      end
      else if (prov_start_in)
        alloc_err_out <= 1'b0;
    end
  end

  // Multiframe length follows the live container, else the requested one
  assign per = live_q ? tsm_pkg::tsm_slots(live_unit_q, live_g25_q) :
                        tsm_pkg::tsm_slots(unit_in, g25_in);
  assign wrap = ({1'b0, mf_q} + 8'h01) >= {1'b0, per};
  assign gmp_live = tsm_pkg::tsm_is_gmp(live_unit_q);

  // Multiframe counter, one slot overhead per frame in ascending order
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      mf_q <= 7'h00;
    else if (frame_start_in)
      mf_q <= wrap ? 7'h00 : 7'(mf_q + 7'h01); // RULE22
  end

  // Ownership of the current slot overhead
  assign mine = live_q && mf_q < 7'(MAX_TS) && live_map_q[mf_q];
  assign unit_oh = gmp_live ? (mine && 7'(mf_q + 7'h01) == live_last_q) : // RULE10
                   mine; // RULE5

  // Slot overhead position outputs
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mf_id_out <= 7'h00;
      tsoh_owner_out <= 7'h01;
      tsoh_mine_out <= 1'b0;
      tsoh_unit_oh_out <= 1'b0;
      tsoh_rsv_out <= 1'b1;
    end
    else
    begin
      mf_id_out <= mf_q; // RULE1
      tsoh_owner_out <= 7'(mf_q + 7'h01); // RULE1
      tsoh_mine_out <= mine;
      tsoh_unit_oh_out <= unit_oh;
      tsoh_rsv_out <= !unit_oh;
    end
  end

  // Overhead layout of the slot carrying unit overhead
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      oh_bytes_out <= 3'h0;
      oh_njo_out <= 1'b0;
      oh_col_out <= 5'h00;
      oh_rows_out <= 3'h0;
    end
    else if (!unit_oh)
    begin
      oh_bytes_out <= 3'h0;
      oh_njo_out <= 1'b0;
      oh_col_out <= 5'h00;
      oh_rows_out <= 3'h0;
    end
    else if (gmp_live)
    begin
      oh_bytes_out <= `TSM_OH_GMP; // RULE8
      oh_njo_out <= 1'b0;
      oh_col_out <= `TSM_COL_GMP; // RULE20
      oh_rows_out <= `TSM_GMP_ROWS;
    end
    else
    begin
      oh_bytes_out <= `TSM_OH_AMP; // RULE4
      oh_njo_out <= 1'b1; // RULE4
      oh_col_out <= `TSM_COL_AMP;
      oh_rows_out <= `TSM_JC_BYTES + `TSM_NJO_BYTES; // RULE19
    end
  end

  // Payload size and container overhead content
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pay_cols_out <= 15'h0000;
      pay_rows_out <= 8'h00;
      omfi_en_out <= 1'b0;
    end
    else
    begin
      pay_cols_out <= live_q ? tsm_pkg::tsm_cols(live_unit_q, live_ts_q) : 15'h0000;
      pay_rows_out <= live_q ? tsm_pkg::tsm_rows(live_unit_q, live_g25_q) : 8'h00;
      omfi_en_out <= live_q && live_unit_q == tsm_pkg::TSM_GMP4; // RULE17
    end
  end

  // Equivalence of 1.25G and 2.5G forms
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      equiv_out <= 1'b0;
    else if (!live_q || live_g25_q)
      equiv_out <= 1'b0;
    else if (live_unit_q == tsm_pkg::TSM_AMP12)
      equiv_out <= live_map_q[7:4] == live_map_q[3:0]; // RULE18
    else if (live_unit_q == tsm_pkg::TSM_AMP13 || live_unit_q == tsm_pkg::TSM_AMP23)
      equiv_out <= live_map_q[31:16] == live_map_q[15:0]; // RULE18
    else
      equiv_out <= 1'b0;
  end

  // Counter wraps to zero at the end of the multiframe
  AST_MF_WRAP: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE22
    frame_start_in && wrap |=> mf_q == 7'h00)
    else $error("multiframe did not wrap");

  // Counter advances by one per frame
  AST_MF_STEP: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE22
    frame_start_in && !wrap |=> mf_q == 7'($past(mf_q) + 7'h01))
    else $error("multiframe step wrong");

  // Overhead owner is index plus one
  AST_OWNER: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE1
    !frame_start_in ##1 !frame_start_in |-> tsoh_owner_out == 7'(mf_q + 7'h01))
    else $error("overhead owner wrong");

  // Forty-slot container keeps index within 0..39
  AST_MF40: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE1
    live_q && per == `TSM_TS_O50 |-> mf_q < `TSM_TS_O50)
    else $error("index beyond forty slots");

  // Generic overhead only in the last allocated slot
  AST_GMP_LAST: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE10
    tsoh_unit_oh_out && oh_bytes_out == `TSM_OH_GMP |-> tsoh_owner_out == $past(live_last_q))
    else $error("generic overhead in wrong slot");

  // Every slot of an asynchronous unit gets four bytes
  AST_AMP_EACH: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE5
    live_q && !gmp_live && mine |=> tsoh_unit_oh_out && oh_bytes_out == `TSM_OH_AMP && oh_njo_out)
    else $error("asynchronous overhead missing");

  // Rejection shows on the flag and clears acceptance
  AST_REJECT: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE21
    chk_err |=> alloc_err_out && !alloc_ok_out ##1 alloc_err_out || prov_start_in)
    else $error("reject not flagged");

  // Generic overhead columns and rows
  AST_GMP_OH: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE20
    live_q && gmp_live && unit_oh |=> oh_col_out == `TSM_COL_GMP && oh_rows_out == `TSM_GMP_ROWS)
    else $error("generic overhead position wrong");

  // Index holds between frame pulses
  AST_MF_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE22
    !frame_start_in |=> mf_q == $past(mf_q))
    else $error("multiframe index moved without frame");

  // Acceptance puts the allocation in force and clears the reject flag
  AST_ACCEPT: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE21
    chk_acc |=> alloc_ok_out && !alloc_err_out && live_q)
    else $error("accept not applied");

  // Asynchronous overhead sits in column 16 over four rows
  AST_AMP_OH: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE19
    live_q && !gmp_live && unit_oh |=> oh_col_out == `TSM_COL_AMP && oh_rows_out == 3'h4)
    else $error("asynchronous overhead position wrong");

  // Slots without unit overhead show no overhead layout
  AST_OH_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE4
    !unit_oh |=> oh_bytes_out == 3'h0 && !oh_njo_out && oh_col_out == 5'h00)
    else $error("overhead layout left in empty slot");

  // Generic overhead is six bytes with no payload byte
  AST_GMP_NJO: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE8
    gmp_live && unit_oh |=> oh_bytes_out == `TSM_OH_GMP && !oh_njo_out)
    else $error("generic overhead size wrong");

  // Identifier byte flagged only for the order-4 generic unit
  AST_OMFI: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE17
    omfi_en_out |-> $past(live_q) && $past(live_unit_q) == tsm_pkg::TSM_GMP4)
    else $error("identifier flag for wrong unit");

  // 2.5G allocations never report the equivalence
  AST_EQUIV_G25: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE18
    live_q && live_g25_q |=> !equiv_out)
    else $error("equivalence on 2.5G form");

  // Main scenarios
  CV_WRAP: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    frame_start_in && wrap && live_q);
  CV_ACCEPT: cover property (@(posedge clk_in) disable iff (sys_rst_in) chk_acc);
  CV_REJECT: cover property (@(posedge clk_in) disable iff (sys_rst_in) chk_err);
  CV_GMP_OH: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    tsoh_unit_oh_out && oh_bytes_out == `TSM_OH_GMP);
  CV_EQUIV: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    equiv_out);
endmodule : tsm_slot_mux

// ==== verif/tsm_prov_src.sv ====
// Partner model: provisioning source and frame pulser feeding the multiplexer
`timescale 1ns/1ps
module tsm_prov_src (
  input wire logic clk_in, // System clock
  output logic frame_start_out, // Frame pulse
  output logic prov_start_out, // Allocation start
  output logic prov_valid_out, // Slot number valid
  output logic [6:0] prov_slot_out, // Slot number
  output logic prov_last_out // Final slot
);
  // Quiet lines at time zero
  initial
  begin
    frame_start_out = 1'b0;
    prov_start_out = 1'b0;
    prov_valid_out = 1'b0;
    prov_slot_out = 7'h55;
    prov_last_out = 1'b0;
  end

  // One cycle of drive, launched just after a rising edge
  task automatic cyc(input logic st, input logic v, input logic [6:0] s, input logic l,
                     input logic f);
    @(posedge clk_in);
    #1;
    frame_start_out = f;
    prov_start_out = st;
    prov_valid_out = v;
    prov_slot_out = v ? s : ~prov_slot_out; // Idle slot bus never keeps a stale value
    prov_last_out = l;
  endtask : cyc

  // Start, then slots back to back, last one flagged
  task automatic alloc(input logic [6:0] q[$]);
    cyc(1'b1, 1'b0, 7'h00, 1'b0, 1'b0);
    foreach (q[i])
      cyc(1'b0, 1'b1, q[i], i == q.size() - 1, 1'b0);
    cyc(1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
  endtask : alloc

  // One frame boundary pulse
  task automatic frame();
    cyc(1'b0, 1'b0, 7'h00, 1'b0, 1'b1);
    cyc(1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
  endtask : frame
endmodule : tsm_prov_src

// ==== verif/tributary_unit_slot_mux_tb_top.sv ====
// Self-checking testbench for the tributary slot multiplexer
`timescale 1ns/1ps
module tributary_unit_slot_mux_tb_top;
  logic clk_in, sys_rst_in, g25_in, fs, ps, pv, pl;
  logic ok, err, mine, uoh, rsv, njo, omfi, eqv;
  logic [6:0] ts_in, slot, mf, owner;
  logic [2:0] ohb, ohr;
  logic [4:0] ohc;
  logic [14:0] cols;
  logic [7:0] rows;
  tsm_pkg::tsm_unit_t unit_in;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  tsm_prov_src tsm_prov_src_inst (.clk_in(clk_in), .frame_start_out(fs), .prov_start_out(ps),
    .prov_valid_out(pv), .prov_slot_out(slot), .prov_last_out(pl));

  tsm_slot_mux tsm_slot_mux_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .frame_start_in(fs), .unit_in(unit_in), .g25_in(g25_in), .ts_in(ts_in),
    .prov_start_in(ps), .prov_valid_in(pv), .prov_slot_in(slot), .prov_last_in(pl),
    .alloc_ok_out(ok), .alloc_err_out(err), .mf_id_out(mf), .tsoh_owner_out(owner),
    .tsoh_mine_out(mine), .tsoh_unit_oh_out(uoh), .tsoh_rsv_out(rsv), .oh_bytes_out(ohb),
    .oh_njo_out(njo), .oh_col_out(ohc), .oh_rows_out(ohr), .pay_cols_out(cols),
    .pay_rows_out(rows), .omfi_en_out(omfi), .equiv_out(eqv));

  // 25 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Run ceiling
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  // Let the answer land: outputs settle within three edges
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic setu(input tsm_pkg::tsm_unit_t u, input logic g, input logic [6:0] t);
    @(posedge clk_in);
    #1;
    unit_in = u;
    g25_in = g;
    ts_in = t;
  endtask : setu

  // Step frames until the wanted slot owns the overhead, bounded
  task automatic goto(input logic [6:0] target);
    for (int i = 0; i < 100 && owner !== target; i++)
    begin
      tsm_prov_src_inst.frame();
      settle();
    end
    chk_val(15'(owner), 15'(target));
  endtask : goto

  task automatic run_alloc(input logic [6:0] q[$]);
    tsm_prov_src_inst.alloc(q);
    settle();
  endtask : run_alloc

  task automatic expect_rej(input logic [6:0] q[$]);
    run_alloc(q);
    chk_bit(err, 1'b1);
    chk_bit(ok, 1'b0);
  endtask : expect_rej

  task automatic t_reset();
    chk_bit(ok, 1'b0);
    chk_val(15'(owner), 15'h0001);
    chk_val(15'(mf), 15'h0000);
    chk_bit(rsv, 1'b1);
    $display("done reset");
  endtask : t_reset

  task automatic t_amp12();
    setu(tsm_pkg::TSM_AMP12, 1'b0, 7'h00);
    run_alloc('{7'h02, 7'h07});
    chk_bit(ok, 1'b1);
    chk_val(cols, 15'h03B8);
    chk_val(15'(rows), 15'h0020);
    chk_bit(eqv, 1'b0);
    run_alloc('{7'h03, 7'h07});
    chk_bit(eqv, 1'b1);
    goto(7'h07);
    chk_bit(mine, 1'b1);
    chk_bit(uoh, 1'b1);
    chk_val(15'(ohb), 15'h0004);
    chk_bit(njo, 1'b1);
    chk_val(15'(ohc), 15'h0010);
    chk_val(15'(ohr), 15'h0004);
    goto(7'h08);
    chk_bit(mine, 1'b0);
    chk_bit(rsv, 1'b1);
    chk_val(15'(ohb), 15'h0000);
    $display("done amp12");
  endtask : t_amp12

  task automatic t_reject();
    expect_rej('{7'h07, 7'h03});
    expect_rej('{7'h02});
    expect_rej('{7'h04, 7'h09});
    expect_rej('{7'h01, 7'h02, 7'h03});
    setu(tsm_pkg::TSM_AMP01, 1'b1, 7'h00);
    expect_rej('{7'h01});
    setu(tsm_pkg::TSM_GMP2, 1'b0, 7'h09);
    expect_rej('{7'h01});
    setu(tsm_pkg::TSM_GMP3, 1'b1, 7'h01);
    expect_rej('{7'h01});
    setu(tsm_pkg::TSM_GMP3, 1'b0, 7'h00);
    expect_rej('{7'h01});
    $display("done reject");
  endtask : t_reject

  task automatic t_gmp_table();
    tsm_pkg::tsm_unit_t ut[5];
    logic [14:0] jv[5];
    logic [7:0] rv[5];
    ut = '{tsm_pkg::TSM_GMP2, tsm_pkg::TSM_GMP3, tsm_pkg::TSM_GMP4, tsm_pkg::TSM_GMP25,
           tsm_pkg::TSM_GMP50};
    jv = '{15'h01DC, 15'h0077, 15'h005F, 15'h03B8, 15'h01DC};
    rv = '{8'h20, 8'h80, 8'hA0, 8'h10, 8'h20};
    for (int i = 0; i < 5; i++)
    begin
      setu(ut[i], 1'b0, 7'h01);
      run_alloc('{7'h01});
      chk_bit(ok, 1'b1);
      chk_val(cols, jv[i]);
      chk_val(15'(rows), 15'(rv[i]));
      chk_bit(omfi, i == 2);
    end
    $display("done gmp table");
  endtask : t_gmp_table

  task automatic t_gmp4();
    setu(tsm_pkg::TSM_GMP4, 1'b0, 7'h03);
    run_alloc('{7'h05, 7'h28, 7'h50});
    chk_bit(ok, 1'b1);
    chk_val(cols, 15'h011D);
    goto(7'h28);
    chk_bit(mine, 1'b1);
    chk_bit(uoh, 1'b0);
    goto(7'h50);
    chk_bit(uoh, 1'b1);
    chk_val(15'(ohb), 15'h0006);
    chk_bit(njo, 1'b0);
    chk_val(15'(ohc), 15'h000F);
    chk_val(15'(ohr), 15'h0003);
    $display("done gmp4");
  endtask : t_gmp4

  task automatic t_amp_misc();
    setu(tsm_pkg::TSM_AMP23, 1'b1, 7'h00);
    run_alloc('{7'h01, 7'h05, 7'h09, 7'h0A});
    chk_val(cols, 15'h03B8);
    chk_val(15'(rows), 15'h0040);
    goto(7'h09);
    chk_bit(uoh, 1'b1);
    setu(tsm_pkg::TSM_AMP23, 1'b0, 7'h00);
    run_alloc('{7'h01, 7'h02, 7'h03, 7'h04, 7'h11, 7'h12, 7'h13, 7'h14});
    chk_val(15'(rows), 15'h0080);
    chk_bit(eqv, 1'b1);
    setu(tsm_pkg::TSM_AMP13, 1'b1, 7'h00);
    run_alloc('{7'h10});
    chk_val(cols, 15'h00EE);
    setu(tsm_pkg::TSM_AMP01, 1'b0, 7'h00);
    run_alloc('{7'h02});
    chk_val(cols, 15'h0770);
    chk_val(15'(rows), 15'h0008);
    $display("done amp misc");
  endtask : t_amp_misc

  task automatic t_wrap();
    logic [6:0] q[$];
    for (int i = 1; i <= 40; i++)
      q.push_back(7'(i));
    setu(tsm_pkg::TSM_GMP50, 1'b0, 7'h28);
    run_alloc(q);
    chk_bit(ok, 1'b1);
    goto(7'h28);
    for (int k = 1; k <= 40; k++)
    begin
      tsm_prov_src_inst.frame();
      settle();
      chk_val(15'(owner), 15'(k));
      chk_val(15'(mf), 15'(k - 1));
      chk_bit(mine, 1'b1);
    end
    $display("done wrap");
  endtask : t_wrap

  // Main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    unit_in = tsm_pkg::TSM_AMP12;
    g25_in = 1'b0;
    ts_in = 7'h00;
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_reset();
    t_amp12();
    t_reject();
    t_gmp_table();
    t_gmp4();
    t_amp_misc();
    t_wrap();
    print_verdict();
  end
endmodule : tributary_unit_slot_mux_tb_top
